// >>> shared/pxa_pkg.sv
// constants shared by both ends of the port expander link
package pxa_pkg;
  // port and address layout
  localparam int PORT_W = 8;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [2:0] ADDR_FIXED = 3'h6;
  localparam logic [3:0] BIT_LAST = 4'h8;
  // strap connection codes of the address select pins
  localparam logic [1:0] CONN_GND = 2'h0;
  localparam logic [1:0] CONN_VPLUS = 2'h1;
  localparam logic [1:0] CONN_SCL = 2'h2;
  localparam logic [1:0] CONN_SDA = 2'h3;
  // serial clock timing of the controller
  localparam int CLK_NS = 25;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_NS;
  // controller registers on apb
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_RW = 7;
  localparam int CTRL_CNT_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_DONE = 2;

  // upper two address bits from the high select strap
  function automatic logic [1:0] pxa_high_bits(input logic [1:0] c);
    case (c)
      CONN_SCL: pxa_high_bits = 2'h0;
      CONN_SDA: pxa_high_bits = 2'h1;
      CONN_GND: pxa_high_bits = 2'h2;
      default: pxa_high_bits = 2'h3;
    endcase
  endfunction

  // lower two address bits from the low select strap
  function automatic logic [1:0] pxa_low_bits(input logic [1:0] c);
    case (c)
      CONN_GND: pxa_low_bits = 2'h0;
      CONN_VPLUS: pxa_low_bits = 2'h1;
      CONN_SCL: pxa_low_bits = 2'h2;
      default: pxa_low_bits = 2'h3;
    endcase
  endfunction
endpackage

// >>> shared/pxa_if.sv
// two-wire link between controller and expander, open-drain resolution
`timescale 1ns/100ps
`default_nettype none
interface pxa_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // pulled high unless some party drives low
  assign scl = (host_scl_oe & ~host_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o)) ? 1'b0 : 1'b1;
  modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                output host_sda_oe, input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// >>> logic/pxa_sync.sv
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pxa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  // stage one feeds only stage two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ff1 <= INIT;
      ff2 <= INIT;
      ff3 <= INIT;
      dout <= INIT;
    end else begin
      ff1 <= din;
      ff2 <= ff1;
      ff3 <= ff2;
      dout <= (ff2 & ~(ff2 ^ ff3)) | (dout & (ff2 ^ ff3)); // glitch filter
    end
  end
endmodule // pxa_sync
`default_nettype wire

// >>> logic/pxa_device.sv
// expander end: serial slave, port latch, snapshot compare and change alert
// Operation
// RULE1: master starts transfers and drives clock
// RULE2: start, address plus direction, bytes, stop
// RULE3: idle high; start/stop are sda edges
// RULE4: one bit per clock; sda stable while high
// RULE5: ninth clock carries receiver's low acknowledge
// RULE6: device acks received bytes; master acks reads
// RULE7: eighth bit low writes, high reads
// RULE8: address 110 plus four strap-decoded bits
// RULE9: address ack clears flags, releases alert
// RULE10: one-byte read returns port states
// RULE11: second read byte holds captured flags
// RULE12: longer reads alternate, resample, clear flags
// RULE13: no alert during read; reassert after stop
// RULE14: port data sampled in preceding acknowledge
// RULE15: write acks each byte and updates ports
// RULE16: master nacks last read byte, then stop
// RULE17: snapshot equals sent data; alert waits stop
// RULE18: write address ack snapshots, releases alert
// RULE19: sda open-drain in/out, scl input only
// RULE20: compare snapshot always; flag and alert
// RULE21: abort returns link idle, alert untouched
// RULE22: one releases port, zero drives low
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pxa_device #(
  parameter logic [7:0] PORT_INIT = pxa_pkg::PORT_RESET
) (
  input wire logic clk,
  input wire logic arst_n,
  pxa_if.dev bus,
  input wire logic abort_n,
  input wire logic [1:0] addr_select_low_pin,
  input wire logic [1:0] addr_select_high_pin,
  input wire logic [pxa_pkg::PORT_W-1:0] io_port_pins_i,
  output logic [pxa_pkg::PORT_W-1:0] io_port_pins_o,
  output logic [pxa_pkg::PORT_W-1:0] io_port_pins_oe,
  output logic change_alert_n
);
  import pxa_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_AACK, D_WR, D_WACK, D_RD, D_RACK, D_SKIP
  } pxa_dstate_e;

  localparam int SW = PORT_W + 7;

  pxa_dstate_e state;
  logic [SW-1:0] sync_out;
  logic [PORT_W-1:0] port_s;
  logic [1:0] low_s;
  logic [1:0] high_s;
  logic scl_s;
  logic sda_s;
  logic abort_s;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic rw_read;
  logic flag_next;
  logic in_read;
  logic sda_drv;
  logic addr_hit;
  logic take_snap;
  logic [PORT_W-1:0] snapshot;
  logic [PORT_W-1:0] flags;
  logic [PORT_W-1:0] flags_cap;
  logic [6:0] my_addr;

  // every outside input, straps included, goes through the synchroniser
  pxa_sync #(.W(SW), .INIT('1)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({abort_n, bus.scl, bus.sda, addr_select_high_pin, addr_select_low_pin,
          io_port_pins_i}),
    .dout(sync_out)
  );

  assign abort_s = sync_out[SW-1];
  assign scl_s = sync_out[SW-2];
  assign sda_s = sync_out[SW-3];
  assign high_s = sync_out[SW-4 -: 2];
  assign low_s = sync_out[SW-6 -: 2];
  assign port_s = sync_out[PORT_W-1:0];

  // straps are re-decoded continuously, so a rewired address takes effect live
  assign my_addr = {ADDR_FIXED, pxa_high_bits(high_s), pxa_low_bits(low_s)}; // RULE8

  // previous line levels for edge and condition detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_seen = scl_s & scl_q & sda_q & ~sda_s; // RULE3
  assign stop_seen = scl_s & scl_q & ~sda_q & sda_s; // RULE3

  // address ack begins at the fall after the eighth bit
  // an aborted link must not snapshot or release the alert on a stray edge
  assign addr_hit = abort_s && (state == D_ADDR) && scl_fall && (bit_cnt == BIT_LAST)
                    && (rx_sh[7:1] == my_addr); // RULE9
  // port byte about to go out: take snapshot during the acknowledge before it
  assign take_snap = addr_hit
                     || (abort_s && (state == D_RACK) && scl_rise && !sda_s
                         && !flag_next); // RULE14

  // serial sequencer, advanced by edges of the master's clock; abort, stop and start override it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= D_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      rw_read <= 1'b0;
      flag_next <= 1'b0;
      sda_drv <= 1'b0;
    end else if (!abort_s) begin
      state <= D_IDLE; // RULE21
      sda_drv <= 1'b0;
    end else if (stop_seen) begin
      state <= D_IDLE; // RULE2
      sda_drv <= 1'b0;
    end else if (start_seen) begin
      state <= D_ADDR; // RULE2
      bit_cnt <= 4'h0;
      sda_drv <= 1'b0;
    end else begin
      case (state)
        D_ADDR: begin
          if (scl_rise) begin
            rx_sh <= {rx_sh[6:0], sda_s}; // RULE4
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BIT_LAST) begin
            if (addr_hit) begin
              state <= D_AACK;
              sda_drv <= 1'b1; // RULE5
              rw_read <= rx_sh[0]; // RULE7
              tx_sh <= port_s; // RULE10
              flag_next <= 1'b1;
            end else begin
              state <= D_SKIP;
            end
          end
        end
        D_AACK, D_WACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (state == D_AACK && rw_read) begin
              state <= D_RD;
              sda_drv <= ~tx_sh[7];
              tx_sh <= {tx_sh[6:0], 1'b0};
            end else begin
              state <= D_WR;
              sda_drv <= 1'b0;
            end
          end
        end
        D_WR: begin
          if (scl_rise) begin
            rx_sh <= {rx_sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BIT_LAST) begin
            state <= D_WACK;
            sda_drv <= 1'b1; // RULE6
          end
        end
        D_RD: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BIT_LAST) begin
              state <= D_RACK;
              sda_drv <= 1'b0;
            end else begin
              sda_drv <= ~tx_sh[7]; // RULE19
              tx_sh <= {tx_sh[6:0], 1'b0};
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state <= D_SKIP; // RULE16
            end else if (flag_next) begin
              tx_sh <= flags_cap; // RULE11
              flag_next <= 1'b0;
            end else begin
              tx_sh <= port_s; // RULE12
              flag_next <= 1'b1;
            end
          end else if (scl_fall) begin
            state <= D_RD;
            bit_cnt <= 4'h0;
            sda_drv <= ~tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
          end
        end
        default: begin
          sda_drv <= 1'b0; // idle or foreign transfer: wait for stop
        end
      endcase
    end
  end

  // data line pulls low only; the clock line is never driven
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_drv; // RULE19

  // read session marker, held until stop, start or abort so the alert stays quiet
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_read <= 1'b0;
    end else if (!abort_s || stop_seen || start_seen) begin
      in_read <= 1'b0; // RULE13
    end else if (addr_hit && rx_sh[0]) begin
      in_read <= 1'b1;
    end
  end

  // snapshot compare; the new snapshot equals the port data just captured
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      snapshot <= PORT_INIT;
      flags <= '0;
      flags_cap <= '0;
    end else if (take_snap) begin
      snapshot <= port_s; // RULE17
      flags_cap <= flags;
      flags <= '0; // RULE12
    end else begin
      flags <= flags | (port_s ^ snapshot); // RULE20
    end
  end

  // alert released at every address ack, asserted again only outside reads
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      change_alert_n <= 1'b1;
    end else if (addr_hit) begin
      change_alert_n <= 1'b1; // RULE18
    end else if (!in_read && (|flags)) begin
      change_alert_n <= 1'b0; // RULE13
    end
  end

  // port latch: each received write byte lands when the device acks it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_port_pins_o <= '0;
      io_port_pins_oe <= ~PORT_INIT;
    end else if (abort_s && !stop_seen && !start_seen && state == D_WR && scl_fall
                 && bit_cnt == BIT_LAST) begin
      io_port_pins_oe <= ~rx_sh; // RULE15 RULE22
    end
  end
endmodule // pxa_device
`default_nettype wire

// >>> logic/pxa_host.sv
// controller end: apb registers, clock divider and two-wire master sequencer
`timescale 1ns/100ps
`default_nettype none
module pxa_host #(
  parameter int QTR_CYC = pxa_pkg::SCL_QUARTER_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [pxa_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pxa_if.host bus
);
  import pxa_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} pxa_hstate_e;

  pxa_hstate_e state;
  logic [15:0] div;
  logic tick;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  logic [7:0] left;
  logic is_addr;
  logic ack_bad;
  logic scl_drv;
  logic sda_drv;
  logic sda_s;
  logic [6:0] cmd_addr;
  logic cmd_rw;
  logic [7:0] cmd_cnt;
  logic [7:0] tx_data;
  logic [15:0] rx_data;
  logic busy;
  logic nack;
  logic done;
  logic go;
  logic acc;
  logic sending;

  // data line read back through the synchroniser for ack and read bits
  pxa_sync #(.W(1), .INIT(1'h1)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(bus.sda),
    .dout(sda_s)
  );

  // quarter-bit enable from a free-running divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 16'h0000;
    end else if (div == 16'(QTR_CYC - 1)) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end
  assign tick = (div == 16'(QTR_CYC - 1));

  // bytes we transmit: the address, and every data byte of a write
  assign sending = is_addr || !cmd_rw;

  // bit sequencer: master alone makes start, stop and every clock pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= H_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      left <= 8'h00;
      is_addr <= 1'b0;
      ack_bad <= 1'b0;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      rx_data <= 16'h0000;
      busy <= 1'b0;
      nack <= 1'b0;
      done <= 1'b0;
    end else if (state == H_IDLE) begin
      phase <= 2'h0;
      if (go) begin
        state <= H_START; // RULE1
        busy <= 1'b1;
        nack <= 1'b0;
        done <= 1'b0;
        left <= cmd_cnt;
      end
    end else if (tick) begin
      phase <= phase + 2'h1;
      case (state)
        H_START: begin
          if (phase == 2'h1) sda_drv <= 1'b1; // RULE3
          if (phase == 2'h2) scl_drv <= 1'b1;
          if (phase == 2'h3) begin
            state <= H_BIT; // RULE2
            bit_cnt <= 4'h0;
            is_addr <= 1'b1;
            sh <= {cmd_addr, cmd_rw}; // RULE7
          end
        end
        H_BIT: begin
          case (phase)
            2'h0: begin
              if (bit_cnt != BIT_LAST) sda_drv <= sending & ~sh[7]; // RULE4
              else sda_drv <= !sending && (left != 8'h01); // RULE16
            end
            2'h1: scl_drv <= 1'b0;
            2'h2: begin
              if (bit_cnt != BIT_LAST) sh <= {sh[6:0], sda_s};
              else ack_bad <= sda_s; // RULE5
            end
            default: begin
              scl_drv <= 1'b1;
              if (bit_cnt != BIT_LAST) begin
                bit_cnt <= bit_cnt + 4'h1;
              end else begin
                bit_cnt <= 4'h0;
                if (sending && ack_bad) begin
                  nack <= 1'b1; // RULE6
                  state <= H_STOP;
                end else if (is_addr) begin
                  is_addr <= 1'b0;
                  sh <= tx_data;
                end else begin
                  if (cmd_rw) rx_data <= {rx_data[7:0], sh};
                  left <= left - 8'h01;
                  sh <= tx_data;
                  if (left == 8'h01) state <= H_STOP;
                end
              end
            end
          endcase
        end
        default: begin
          if (phase == 2'h0) sda_drv <= 1'b1;
          if (phase == 2'h1) scl_drv <= 1'b0;
          if (phase == 2'h2) sda_drv <= 1'b0; // RULE3
          if (phase == 2'h3) begin
            state <= H_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  // both lines open-drain: low when driven, else released
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_drv;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_drv;

  // apb slave: no wait state; prdata and pready both come from flops set during the setup phase
  assign acc = psel & penable & pready;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !(paddr == REG_CTRL || paddr == REG_TXDATA || paddr == REG_RXDATA
                   || paddr == REG_STATUS);
      case (paddr)
        REG_CTRL: prdata <= {16'h0000, cmd_cnt, cmd_rw, cmd_addr};
        REG_TXDATA: prdata <= {24'h000000, tx_data};
        REG_RXDATA: prdata <= {16'h0000, rx_data};
        REG_STATUS: prdata <= {29'h0, done, nack, busy};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // register writes; a command written while busy is dropped, one with zero count is stored but starts nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_addr <= 7'h00;
      cmd_rw <= 1'b0;
      cmd_cnt <= 8'h00;
      tx_data <= 8'h00;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (acc && pwrite && paddr == REG_TXDATA) tx_data <= pwdata[7:0];
      if (acc && pwrite && paddr == REG_CTRL && !busy && !go) begin
        cmd_addr <= pwdata[6:0];
        cmd_rw <= pwdata[CTRL_RW];
        cmd_cnt <= pwdata[CTRL_CNT_LSB +: 8];
        go <= (pwdata[CTRL_CNT_LSB +: 8] != 8'h00);
      end
    end
  end
endmodule // pxa_host
`default_nettype wire

// >>> bench/pxa_link_checker.sv
// wire-level assertions on the two-wire link between controller and expander
`timescale 1ns/100ps
`default_nettype none
module pxa_link_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic in_frame;
  int rises;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // previous wire levels, reset to the pulled-up idle state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // frame flag and clock pulse count since the last start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_frame <= 1'b0;
      rises <= 0;
    end else if (scl && scl_q && sda_q && !sda) begin
      in_frame <= 1'b1;
      rises <= 0;
    end else begin
      if (scl && scl_q && !sda_q && sda) in_frame <= 1'b0;
      if (scl && !scl_q) rises <= rises + 1;
    end
  end
  // start, stop and idle levels
  a_idle_after_reset: assert property ($rose(arst_n) |-> scl && sda)
    else $error("link not idle high after reset");
  a_start_by_host: assert property ($fell(sda) && scl |-> $rose(host_sda_oe) && !dev_sda_oe)
    else $error("sda fell with scl high without a controller start");
  a_stop_then_free: assert property ($rose(sda) && scl |-> $fell(host_sda_oe) ##1 scl [*8])
    else $error("sda rose with scl high without a clean stop");
  // expander drives only inside a frame, open drain, stable while scl high
  a_dev_in_frame: assert property (dev_sda_oe |-> in_frame)
    else $error("expander drove sda outside a frame");
  a_open_drain_only: assert property (!dev_sda_o && !host_sda_o && !host_scl_o)
    else $error("a party drove a line high");
  a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("expander changed sda while scl high");
  a_dev_low_held: assert property ($rose(dev_sda_oe) |-> !scl ##1 dev_sda_oe [*8])
    else $error("expander low bit not set up in scl low or not held");
  // nine pulses per byte plus the pulse of the stop
  a_nine_bit_units: assert property ($rose(sda) && scl && in_frame |-> rises % 9 == 1)
    else $error("frame did not hold whole nine-bit units");
endmodule // pxa_link_checker
`default_nettype wire

// >>> bench/i2c_port_expander_access_tb.sv
// self-checking bench: apb-driven controller talking to the expander
`timescale 1ns/100ps
`default_nettype none
module i2c_port_expander_access_tb;
  import pxa_pkg::*;
  localparam logic [7:0] HI_MAP = 8'h4E; // high strap code to upper address bits
  localparam logic [6:0] DEV_A = 7'h67; // address with both straps on the data line
  logic clk;
  logic arst_n;
  logic [APB_AW-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic abort_n;
  logic [1:0] sel_lo;
  logic [1:0] sel_hi;
  logic [7:0] pin_drv;
  logic [7:0] pins_o;
  logic [7:0] pins_oe;
  logic alert_n;
  logic [31:0] rd_v;
  logic [31:0] st;
  logic er;
  int fail_count;
  int checks_done;
  pxa_if bus_if ();
  // short quarter count keeps the serial frames brief
  pxa_host #(.QTR_CYC(8)) u_pxa_host (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus_if));
  pxa_device u_pxa_device (.clk(clk), .arst_n(arst_n), .bus(bus_if), .abort_n(abort_n),
    .addr_select_low_pin(sel_lo), .addr_select_high_pin(sel_hi), .io_port_pins_i(pin_drv),
    .io_port_pins_o(pins_o), .io_port_pins_oe(pins_oe), .change_alert_n(alert_n));
  pxa_link_checker u_pxa_link_checker (.clk(clk), .arst_n(arst_n),
    .host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe),
    .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  // free-running bench clock, 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // one apb transfer; the edge before it keeps drivers from double assignment
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [6:0] a, input logic r, input logic [7:0] n);
    apb(REG_CTRL, 1'b1, {16'h0, n, r, a});
  endtask
  // poll status until the stop has gone out
  task automatic wait_done();
    repeat (4) @(posedge clk);
    do apb(REG_STATUS, 1'b0, 32'h0); while (rd_v[ST_DONE] !== 1'b1);
    st = rd_v;
  endtask
  task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] n);
    go(a, r, n);
    wait_done();
    apb(REG_RXDATA, 1'b0, 32'h0);
  endtask
  task automatic wait_oe(input logic [7:0] v);
    for (int n = 0; n < 3000 && pins_oe !== v; n++) @(posedge clk);
  endtask
  task automatic t_reset();
    chk(32'({alert_n, pins_oe}), 32'h100);
    chk(32'({bus_if.scl, bus_if.sda}), 32'h3);
    apb(8'h10, 1'b0, 32'h0);
    chk(32'({er, rd_v[30:0]}), 32'h8000_0000);
    // register readback; a zero count must not start a transfer
    apb(REG_TXDATA, 1'b1, 32'hA5);
    apb(REG_TXDATA, 1'b0, 32'h0);
    chk(rd_v, 32'hA5);
    go(7'h2B, 1'b1, 8'h0);
    apb(REG_CTRL, 1'b0, 32'h0);
    chk(rd_v, 32'hAB);
    apb(REG_STATUS, 1'b0, 32'h0);
    chk(rd_v, 32'h0);
  endtask
  // every strap pairing answers at its own address, a foreign one is ignored
  task automatic t_straps();
    logic [6:0] a;
    for (int i = 0; i < 16; i++) begin
      sel_hi <= i[3:2];
      sel_lo <= i[1:0];
      pin_drv <= 8'h5A ^ 8'(i);
      a = {3'h6, HI_MAP[2*i[3:2] +: 2], i[1:0]};
      xfer(a, 1'b1, 8'h1);
      chk(32'({st[ST_NACK], rd_v[7:0]}), 32'(8'h5A ^ 8'(i)));
    end
    xfer(7'h5C, 1'b1, 8'h1);
    chk(32'(st[ST_NACK]), 32'h1);
  endtask
  task automatic t_flags();
    pin_drv <= 8'h96;
    xfer(DEV_A, 1'b1, 8'h1);
    pin_drv <= 8'h93;
    repeat (20) @(posedge clk);
    chk(32'(alert_n), 32'h0);
    xfer(DEV_A, 1'b1, 8'h2);
    chk(32'({alert_n, rd_v[15:0]}), 32'h19305);
  endtask
  // a change inside a read holds the alert off until the stop
  task automatic t_change();
    go(DEV_A, 1'b1, 8'h2);
    repeat (450) @(posedge clk);
    pin_drv <= 8'hA4;
    repeat (100) @(posedge clk);
    chk(32'(alert_n), 32'h1);
    wait_done();
    repeat (20) @(posedge clk);
    chk(32'(alert_n), 32'h0);
    apb(REG_RXDATA, 1'b0, 32'h0);
    chk(32'(rd_v[15:0]), 32'h9300);
  endtask
  task automatic t_multi();
    go(DEV_A, 1'b1, 8'h3);
    repeat (450) @(posedge clk);
    pin_drv <= 8'h17;
    wait_done();
    apb(REG_RXDATA, 1'b0, 32'h0);
    chk(32'(rd_v[15:0]), 32'h3717);
  endtask
  // second byte is loaded after the first has been latched
  task automatic t_write();
    pin_drv <= 8'hE1;
    repeat (20) @(posedge clk);
    chk(32'(alert_n), 32'h0);
    apb(REG_TXDATA, 1'b1, 32'h3C);
    go(DEV_A, 1'b0, 8'h2);
    wait_oe(8'hC3);
    chk(32'(pins_oe), 32'hC3);
    apb(REG_TXDATA, 1'b1, 32'hC3);
    wait_done();
    chk(32'({st[ST_NACK], alert_n, pins_o, pins_oe}), 32'h1003C);
  endtask
  // abort after the first byte: the second is neither acked nor latched
  task automatic t_abort();
    apb(REG_TXDATA, 1'b1, 32'h0F);
    go(DEV_A, 1'b0, 8'h2);
    wait_oe(8'hF0);
    apb(REG_TXDATA, 1'b1, 32'h55);
    while (bus_if.scl !== 1'b1) @(posedge clk);
    while (bus_if.scl !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    abort_n <= 1'b0;
    repeat (8) @(posedge clk);
    abort_n <= 1'b1;
    wait_done();
    chk(32'({st[ST_NACK], alert_n, pins_oe}), 32'h3F0);
  endtask
  // cut a hang short
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    arst_n = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    abort_n = 1'b1;
    sel_lo = 2'h0;
    sel_hi = 2'h0;
    pin_drv = 8'hFF;
    fail_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_straps();
    t_flags();
    t_change();
    t_multi();
    t_write();
    t_abort();
    finish_test();
  end
endmodule // i2c_port_expander_access_tb
`default_nettype wire
